// File: src/ctl_field_cfg.svh
/*
  constants for the control field codec: field positions, encodings, widths.
  assumes inclusion by bare name from the codec files.
*/
// What this block does
// - build and check I, S, U control fields
// - repertoire: balanced-mode set plus XID, TEST, UI
// - mod 8 info: bit1=0, send, poll, receive
// - send number field is transmitter send count
// - receive number field is next expected frame
// - bit five is poll for commands, final otherwise
// - fixed mod 8 supervisory and unnumbered encodings
// - SABM encoding; command only; DM UA FRMR responses
// - mod 128 info: 16 bits, poll bit 9
// - mod 128 supervisory layout; SABME encoding
// - unnumbered fields always eight bits
// - XID and UI each enabled separately
`ifndef CTL_FIELD_CFG_SVH
`define CTL_FIELD_CFG_SVH
`define CF_W 16
`define SEQ_W 7
`define KIND_W 4
// low nibble patterns
`define LO_RR 4'h1
`define LO_RNR 4'h5
`define LO_REJ 4'h9
// unnumbered: low nibble, high three bits (bits 6-8, lsb first)
`define U_LO_3 4'h3
`define U_LO_F 4'hF
`define U_LO_7 4'h7
`define U_HI_UI 3'h0
`define U_HI_DM 3'h0
`define U_HI_SABM 3'h1
`define U_HI_DISC 3'h2
`define U_HI_UA 3'h3
`define U_HI_FRMR 3'h4
`define U_HI_XID 3'h5
`define U_HI_SABME 3'h3
`define U_HI_TEST 3'h7
`define PF8_POS 4
`define PF128_POS 8
`define NR8_LSB 5
`define NR128_LSB 9
`define NS_LSB 1
`endif

// File: src/ctl_field_pkg.sv
/*
  types for the control field codec.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ctl_field_pkg;
  typedef enum logic [3:0] {
    K_I = 4'h0, K_RR = 4'h1, K_RNR = 4'h2, K_REJ = 4'h3,
    K_UI = 4'h4, K_SABM = 4'h5, K_SABME = 4'h6, K_DM = 4'h7,
    K_DISC = 4'h8, K_UA = 4'h9, K_FRMR = 4'hA, K_XID = 4'hB,
    K_TEST = 4'hC, K_BAD = 4'hF
  } kind_e;
endpackage

// File: src/ctl_field_enc.sv
/*
  combinational control field builder.
  assumes kind and numbers are held stable by the caller.
*/
`timescale 1ns/1ps
`include "ctl_field_cfg.svh"
module ctl_field_enc (
  input wire logic [3:0] kind,
  input wire logic ext_mode,
  input wire logic pf,
  input wire logic [6:0] ns,
  input wire logic [6:0] nr,
  output logic [15:0] field,
  output logic wide,
  output logic ok
);
  function automatic logic [15:0] sup(input logic [3:0] lo, input logic e,
      input logic p, input logic [6:0] r);
    logic [15:0] f;
    f = 16'h0000;
    f[3:0] = lo;
    if (e) begin
      f[`PF128_POS] = p;
      f[15:9] = r;
    end else begin
      f[`PF8_POS] = p;
      f[7:5] = r[2:0];
    end
    return f;
  endfunction

  function automatic logic [15:0] unum(input logic [3:0] lo, input logic [2:0] hi,
      input logic p);
    return {8'h00, hi, p, lo};
  endfunction

  always_comb begin
    field = 16'h0000;
    wide = 1'b0;
    ok = 1'b1;
    case (ctl_field_pkg::kind_e'(kind))
      ctl_field_pkg::K_I: begin
        wide = ext_mode;
        if (ext_mode) begin
          field = {nr, pf, ns, 1'b0};
        end else begin
          field = {8'h00, nr[2:0], pf, ns[2:0], 1'b0};
        end
      end
      ctl_field_pkg::K_RR: begin
        field = sup(`LO_RR, ext_mode, pf, nr);
        wide = ext_mode;
      end
      ctl_field_pkg::K_RNR: begin
        field = sup(`LO_RNR, ext_mode, pf, nr);
        wide = ext_mode;
      end
      ctl_field_pkg::K_REJ: begin
        field = sup(`LO_REJ, ext_mode, pf, nr);
        wide = ext_mode;
      end
      ctl_field_pkg::K_UI: field = unum(`U_LO_3, `U_HI_UI, pf);
      ctl_field_pkg::K_SABM: field = unum(`U_LO_F, `U_HI_SABM, pf);
      ctl_field_pkg::K_SABME: field = unum(`U_LO_F, `U_HI_SABME, pf);
      ctl_field_pkg::K_DM: field = unum(`U_LO_F, `U_HI_DM, pf);
      ctl_field_pkg::K_DISC: field = unum(`U_LO_3, `U_HI_DISC, pf);
      ctl_field_pkg::K_UA: field = unum(`U_LO_3, `U_HI_UA, pf);
      ctl_field_pkg::K_FRMR: field = unum(`U_LO_7, `U_HI_FRMR, pf);
      ctl_field_pkg::K_XID: field = unum(`U_LO_F, `U_HI_XID, pf);
      ctl_field_pkg::K_TEST: field = unum(`U_LO_3, `U_HI_TEST, pf);
      default: ok = 1'b0;
    endcase
  end
endmodule // ctl_field_enc

// File: src/ctl_field_dec.sv
/*
  combinational control field classifier.
  assumes the whole received field is presented at once, low octet first.
*/
`timescale 1ns/1ps
`include "ctl_field_cfg.svh"
module ctl_field_dec (
  input wire logic [15:0] field,
  input wire logic ext_mode,
  output logic [3:0] kind,
  output logic pf,
  output logic [6:0] ns,
  output logic [6:0] nr
);
  always_comb begin
    kind = ctl_field_pkg::K_BAD;
    pf = field[`PF8_POS];
    ns = 7'h00;
    nr = 7'h00;
    if (!field[0]) begin
      kind = ctl_field_pkg::K_I;
      if (ext_mode) begin
        ns = field[7:1];
        pf = field[`PF128_POS];
        nr = field[15:9];
      end else begin
        ns = {4'h0, field[3:1]};
        nr = {4'h0, field[7:5]};
      end
    end else if (!field[1]) begin
      if (ext_mode) begin
        pf = field[`PF128_POS];
        nr = field[15:9];
      end else begin
        nr = {4'h0, field[7:5]};
      end
      if (!ext_mode || field[7:4] == 4'h0) begin
        case (field[3:0])
          `LO_RR: kind = ctl_field_pkg::K_RR;
          `LO_RNR: kind = ctl_field_pkg::K_RNR;
          `LO_REJ: kind = ctl_field_pkg::K_REJ;
          default: kind = ctl_field_pkg::K_BAD;
        endcase
      end
    end else begin
      case ({field[7:5], field[3:0]})
        {`U_HI_UI, `U_LO_3}: kind = ctl_field_pkg::K_UI;
        {`U_HI_SABM, `U_LO_F}: kind = ctl_field_pkg::K_SABM;
        {`U_HI_SABME, `U_LO_F}: kind = ctl_field_pkg::K_SABME;
        {`U_HI_DM, `U_LO_F}: kind = ctl_field_pkg::K_DM;
        {`U_HI_DISC, `U_LO_3}: kind = ctl_field_pkg::K_DISC;
        {`U_HI_UA, `U_LO_3}: kind = ctl_field_pkg::K_UA;
        {`U_HI_FRMR, `U_LO_7}: kind = ctl_field_pkg::K_FRMR;
        {`U_HI_XID, `U_LO_F}: kind = ctl_field_pkg::K_XID;
        {`U_HI_TEST, `U_LO_3}: kind = ctl_field_pkg::K_TEST;
        default: kind = ctl_field_pkg::K_BAD;
      endcase
    end
  end
endmodule // ctl_field_dec

// File: src/hdlc_control_field_codec.sv
/*
  top of the control field codec: registered build path and check path.
  assumes requests come from same-clock logic; one request per cycle.
*/
`timescale 1ns/1ps
`include "ctl_field_cfg.svh"
module hdlc_control_field_codec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_mode,
  input wire logic xid_en,
  input wire logic ui_en,
  input wire logic tx_req,
  input wire logic [3:0] tx_kind,
  input wire logic tx_is_cmd,
  input wire logic tx_pf,
  input wire logic [6:0] tx_ns,
  input wire logic [6:0] tx_nr,
  output logic tx_done,
  output logic [15:0] tx_field,
  output logic tx_wide,
  output logic tx_err,
  input wire logic rx_req,
  input wire logic [15:0] rx_field,
  input wire logic rx_is_cmd,
  output logic rx_done,
  output logic [3:0] rx_kind,
  output logic [6:0] rx_ns,
  output logic [6:0] rx_nr,
  output logic rx_poll,
  output logic rx_final,
  output logic rx_wide,
  output logic rx_bad
);
  logic [15:0] enc_field;
  logic enc_wide;
  logic enc_ok;
  logic [3:0] dec_kind;
  logic dec_pf;
  logic [6:0] dec_ns;
  logic [6:0] dec_nr;
  logic [6:0] ns_in;
  logic [6:0] nr_in;

  logic next_tx_done;
  logic [15:0] next_tx_field;
  logic next_tx_wide;
  logic next_tx_err;
  logic next_rx_done;
  logic [3:0] next_rx_kind;
  logic [6:0] next_rx_ns;
  logic [6:0] next_rx_nr;
  logic next_rx_poll;
  logic next_rx_final;
  logic next_rx_wide;
  logic next_rx_bad;

  // frame type legal for this role and enable setting
  function automatic logic kind_allowed(input logic [3:0] k, input logic cmd,
      input logic em, input logic xe, input logic ue);
    logic a;
    a = 1'b1;
    case (ctl_field_pkg::kind_e'(k))
      ctl_field_pkg::K_SABM: a = cmd && !em;
      ctl_field_pkg::K_SABME: a = cmd && em;
      ctl_field_pkg::K_DISC: a = cmd;
      ctl_field_pkg::K_DM: a = !cmd;
      ctl_field_pkg::K_UA: a = !cmd;
      ctl_field_pkg::K_FRMR: a = !cmd;
      ctl_field_pkg::K_XID: a = xe;
      ctl_field_pkg::K_UI: a = ue;
      ctl_field_pkg::K_BAD: a = 1'b0;
      default: a = 1'b1;
    endcase
    return a;
  endfunction

  // sequence numbers trimmed to the active modulus
  assign ns_in = ext_mode ? tx_ns : {4'h0, tx_ns[2:0]};
  assign nr_in = ext_mode ? tx_nr : {4'h0, tx_nr[2:0]};

  ctl_field_enc u_enc (
    .kind(tx_kind),
    .ext_mode(ext_mode),
    .pf(tx_pf),
    .ns(ns_in),
    .nr(nr_in),
    .field(enc_field),
    .wide(enc_wide),
    .ok(enc_ok)
  );

  ctl_field_dec u_dec (
    .field(rx_field),
    .ext_mode(ext_mode),
    .kind(dec_kind),
    .pf(dec_pf),
    .ns(dec_ns),
    .nr(dec_nr)
  );

  // build path
  always_comb begin
    next_tx_done = tx_req;
    next_tx_field = tx_field;
    next_tx_wide = tx_wide;
    next_tx_err = tx_err;
    if (tx_req) begin
      if (enc_ok && kind_allowed(tx_kind, tx_is_cmd, ext_mode, xid_en, ui_en)) begin
        next_tx_field = enc_field;
        next_tx_wide = enc_wide;
        next_tx_err = 1'b0;
      end else begin
        next_tx_field = 16'h0000;
        next_tx_wide = 1'b0;
        next_tx_err = 1'b1;
      end
    end
  end

  // check path
  always_comb begin
    next_rx_done = rx_req;
    next_rx_kind = rx_kind;
    next_rx_ns = rx_ns;
    next_rx_nr = rx_nr;
    next_rx_poll = rx_poll;
    next_rx_final = rx_final;
    next_rx_wide = rx_wide;
    next_rx_bad = rx_bad;
    if (rx_req) begin
      next_rx_ns = dec_ns;
      next_rx_nr = dec_nr;
      next_rx_poll = dec_pf && rx_is_cmd;
      next_rx_final = dec_pf && !rx_is_cmd;
      next_rx_wide = ext_mode && (dec_kind == ctl_field_pkg::K_I ||
          dec_kind == ctl_field_pkg::K_RR || dec_kind == ctl_field_pkg::K_RNR ||
          dec_kind == ctl_field_pkg::K_REJ);
      if (kind_allowed(dec_kind, rx_is_cmd, ext_mode, xid_en, ui_en)) begin
        next_rx_kind = dec_kind;
        next_rx_bad = 1'b0;
      end else begin
        next_rx_kind = ctl_field_pkg::K_BAD;
        next_rx_bad = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_done <= 1'b0;
      tx_field <= 16'h0000;
      tx_wide <= 1'b0;
      tx_err <= 1'b0;
      rx_done <= 1'b0;
      rx_kind <= ctl_field_pkg::K_BAD;
      rx_ns <= 7'h00;
      rx_nr <= 7'h00;
      rx_poll <= 1'b0;
      rx_final <= 1'b0;
      rx_wide <= 1'b0;
      rx_bad <= 1'b0;
    end else begin
      tx_done <= next_tx_done;
      tx_field <= next_tx_field;
      tx_wide <= next_tx_wide;
      tx_err <= next_tx_err;
      rx_done <= next_rx_done;
      rx_kind <= next_rx_kind;
      rx_ns <= next_rx_ns;
      rx_nr <= next_rx_nr;
      rx_poll <= next_rx_poll;
      rx_final <= next_rx_final;
      rx_wide <= next_rx_wide;
      rx_bad <= next_rx_bad;
    end
  end
endmodule // hdlc_control_field_codec

// File: bench/remote_station.sv
/*
  remote link station model: echoes each good built field back as a received frame,
  or sends a field chosen by the bench. assumes same clock and reset as the codec.
*/
`timescale 1ns/1ps
module remote_station (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tx_done,
  input wire logic tx_err,
  input wire logic [15:0] tx_field,
  input wire logic cmd,
  input wire logic inject,
  input wire logic [15:0] inject_field,
  output logic rx_req,
  output logic [15:0] rx_field,
  output logic rx_is_cmd
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_req <= 1'b0;
      rx_field <= 16'h0000;
      rx_is_cmd <= 1'b0;
    end else if (inject || (tx_done && !tx_err)) begin
      rx_req <= 1'b1;
      rx_field <= inject ? inject_field : tx_field;
      rx_is_cmd <= cmd;
    end else begin
      rx_req <= 1'b0;
      rx_field <= ~rx_field;
    end
  end
endmodule // remote_station

// File: bench/hdlc_control_field_codec_sva.sv
/*
  checker for the control field codec, bound to its top.
  assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module ctl_codec_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ext_mode,
  input wire logic tx_req,
  input wire logic [3:0] tx_kind,
  input wire logic tx_is_cmd,
  input wire logic tx_pf,
  input wire logic [6:0] tx_ns,
  input wire logic [6:0] tx_nr,
  input wire logic tx_done,
  input wire logic [15:0] tx_field,
  input wire logic tx_wide,
  input wire logic tx_err,
  input wire logic rx_req,
  input wire logic [15:0] rx_field,
  input wire logic rx_is_cmd,
  input wire logic rx_poll,
  input wire logic rx_bad
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [6:0] q_ns;
  logic [6:0] q_nr;
  logic q_pf;
  always_ff @(posedge clk) begin
    q_ns <= tx_ns;
    q_nr <= tx_nr;
    q_pf <= tx_pf;
  end
  done_one_cycle_a: assert property (tx_req |=> tx_done)
    else $error("build answer missing");
  info_mod8_a: assert property (tx_req && tx_kind == 4'h0 && !ext_mode |=>
    tx_field == {8'h00, q_nr[2:0], q_pf, q_ns[2:0], 1'b0}) else $error("mod 8 info field wrong");
  info_mod128_a: assert property (tx_req && tx_kind == 4'h0 && ext_mode |=>
    tx_wide && tx_field == {q_nr, q_pf, q_ns, 1'b0}) else $error("mod 128 info field wrong");
  sup_wide_a: assert property (tx_req && ext_mode && tx_kind inside {4'h1, 4'h2, 4'h3} |=>
    tx_wide && tx_field[7:4] == 4'h0 && tx_field[8] == q_pf) else $error("wide super wrong");
  unnum_narrow_a: assert property (tx_req && tx_kind > 4'h3 |=>
    tx_field[15:8] == 8'h00 && !tx_wide) else $error("unnumbered field not narrow");
  sabm_cmd_only_a: assert property (tx_req && tx_kind == 4'h5 && !tx_is_cmd |=> tx_err)
    else $error("sabm response accepted");
  resp_only_a: assert property (tx_req && tx_kind inside {4'h7, 4'h9, 4'hA} && tx_is_cmd |=>
    tx_err) else $error("response kind accepted as command");
  rx_role_a: assert property (rx_req && !rx_is_cmd |=> !rx_poll)
    else $error("poll flagged on response");
  sup_bits_bad_a: assert property (rx_req && ext_mode && rx_field[1:0] == 2'b01 &&
    rx_field[7:4] != 4'h0 |=> rx_bad) else $error("bad wide super accepted");
  err_zero_a: assert property (tx_err |-> tx_field == 16'h0000 && !tx_wide)
    else $error("refused build left data");
  cover property (tx_done && tx_wide);
  cover property (tx_done && tx_err);
  cover property (rx_bad);
  cover property (rx_req && rx_is_cmd ##1 rx_poll);
endmodule // ctl_codec_chk
bind hdlc_control_field_codec ctl_codec_chk u_ctl_codec_chk (
  .clk(clk), .rst_b(rst_b), .ext_mode(ext_mode), .tx_req(tx_req), .tx_kind(tx_kind),
  .tx_is_cmd(tx_is_cmd), .tx_pf(tx_pf), .tx_ns(tx_ns), .tx_nr(tx_nr), .tx_done(tx_done),
  .tx_field(tx_field), .tx_wide(tx_wide), .tx_err(tx_err), .rx_req(rx_req),
  .rx_field(rx_field), .rx_is_cmd(rx_is_cmd), .rx_poll(rx_poll), .rx_bad(rx_bad)
);

// File: bench/tb_hdlc_control_field_codec.sv
/*
  self-checking bench for the control field codec with a remote station echo.
  assumes the codec answers one cycle after each request.
*/
`timescale 1ns/1ps
module tb_hdlc_control_field_codec;
  logic clk = 1'b0, rst_b = 1'b0, ext_mode = 1'b0, xid_en = 1'b0, ui_en = 1'b0;
  logic tx_req = 1'b0, tx_is_cmd = 1'b0, tx_pf = 1'b0, inject = 1'b0;
  logic [3:0] tx_kind = 4'h0;
  logic [6:0] tx_ns = 7'h00, tx_nr = 7'h00;
  logic [15:0] inj_field = 16'h0000;
  logic tx_done, tx_wide, tx_err, rx_req, rx_is_cmd, rx_done, rx_poll, rx_final, rx_wide, rx_bad;
  logic [15:0] tx_field, rx_field;
  logic [3:0] rx_kind;
  logic [6:0] rx_ns, rx_nr;
  int mismatches = 0, n_tests = 0, cycles = 0;
  initial forever #10 clk = ~clk;
  hdlc_control_field_codec u_hdlc_control_field_codec (
    .clk(clk), .rst_b(rst_b), .ext_mode(ext_mode), .xid_en(xid_en), .ui_en(ui_en),
    .tx_req(tx_req), .tx_kind(tx_kind), .tx_is_cmd(tx_is_cmd), .tx_pf(tx_pf), .tx_ns(tx_ns),
    .tx_nr(tx_nr), .tx_done(tx_done), .tx_field(tx_field), .tx_wide(tx_wide), .tx_err(tx_err),
    .rx_req(rx_req), .rx_field(rx_field), .rx_is_cmd(rx_is_cmd), .rx_done(rx_done),
    .rx_kind(rx_kind), .rx_ns(rx_ns), .rx_nr(rx_nr), .rx_poll(rx_poll), .rx_final(rx_final),
    .rx_wide(rx_wide), .rx_bad(rx_bad));
  remote_station u_remote_station (
    .clk(clk), .rst_b(rst_b), .tx_done(tx_done), .tx_err(tx_err), .tx_field(tx_field),
    .cmd(tx_is_cmd), .inject(inject), .inject_field(inj_field), .rx_req(rx_req),
    .rx_field(rx_field), .rx_is_cmd(rx_is_cmd));
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("tests=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  // {err, wide, field}
  function automatic logic [17:0] exp_tx(input logic [3:0] k, input logic em, c, p, xe, ue,
      input logic [6:0] s, r);
    logic [7:0] u;
    logic [3:0] lo;
    logic e;
    u = 8'h00;
    lo = (k == 4'h1) ? 4'h1 : (k == 4'h2) ? 4'h5 : 4'h9;
    case (k)
      4'h4: u = 8'h03;
      4'h5: u = 8'h2F;
      4'h6: u = 8'h6F;
      4'h7: u = 8'h0F;
      4'h8: u = 8'h43;
      4'h9: u = 8'h63;
      4'hA: u = 8'h87;
      4'hB: u = 8'hAF;
      4'hC: u = 8'hE3;
      default: u = 8'h00;
    endcase
    e = k > 4'hC || (k == 4'h4 && !ue) || (k == 4'h5 && (em || !c)) || (k == 4'h8 && !c) ||
      (k == 4'h6 && (!em || !c)) || (k inside {4'h7, 4'h9, 4'hA} && c) || (k == 4'hB && !xe);
    if (e) return 18'h20000;
    if (k > 4'h3) return {2'b00, 8'h00, u | {3'b000, p, 4'h0}};
    if (em) return {2'b01, r, p, (k == 4'h0) ? {s, 1'b0} : {4'h0, lo}};
    return {2'b00, 8'h00, r[2:0], p, (k == 4'h0) ? {s[2:0], 1'b0} : lo};
  endfunction
  task xfer(input logic [3:0] k, input logic em, c, p, xe, ue, input logic [6:0] s, r);
    logic [17:0] e;
    logic [6:0] m;
    e = exp_tx(k, em, c, p, xe, ue, s, r);
    m = em ? 7'h7F : 7'h07;
    {tx_kind, ext_mode, tx_is_cmd, tx_pf, xid_en, ui_en, tx_ns, tx_nr} = {k, em, c, p, xe, ue, s, r};
    tx_req = 1'b1;
    @(posedge clk) #1;
    tx_req = 1'b0;
    chk({tx_done, tx_err, tx_wide, tx_field}, {1'b1, e});
    @(posedge clk) #1;
    chk(tx_done, 1'b0);
    if (!e[17]) begin
      @(posedge clk) #1;
      chk({rx_done, rx_bad, rx_wide, rx_kind, rx_poll, rx_final}, {2'b10, e[16], k, p & c, p & !c});
      chk({rx_ns, rx_nr}, {(k == 4'h0) ? s & m : 7'h00, (k < 4'h4) ? r & m : 7'h00});
    end
  endtask
  task inj(input logic [15:0] f, input logic em, xe);
    {ext_mode, xid_en, inj_field, inject} = {em, xe, f, 1'b1};
    @(posedge clk) #1;
    inject = 1'b0;
    @(posedge clk) #1;
    chk({rx_done, rx_bad, rx_kind}, {2'b11, 4'hF});
  endtask
  initial begin
    logic [31:0] rn;
    rn = $urandom(77);
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    xfer(4'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 7'h00, 7'h05);
    for (int i = 0; i < 64; i++) xfer(i[3:0], i[4], i[5], i[0], 1'b1, 1'b1, 7'h7F, 7'h55);
    repeat (150) begin
      rn = $urandom;
      xfer(rn[3:0], rn[4], rn[5], rn[6], rn[7], rn[8], rn[15:9], rn[22:16]);
    end
    inj(16'h00FF, 1'b0, 1'b1);
    inj(16'h0011, 1'b1, 1'b1);
    inj(16'h00BF, 1'b0, 1'b0);
    close_out();
  end
endmodule // tb_hdlc_control_field_codec
